// [dv/ccr_host_model.sv]
// Purpose: host processor on the serial data port
// Assumes: 48 ns port clock made only by these tasks
// Notes: released data line toggles so nothing reads as stale

`timescale 1ns/1ps
`default_nettype none

// ****************************************************************
// host model
// ****************************************************************
module ccr_host_model (
  // toward the block
  output logic port_clock,
  output logic frame_n,
  output logic port_din,
  // answer from the block
  input wire logic port_dout,
  input wire logic port_dout_oe
);
  // idle levels
  initial begin
    port_clock = 1'b0;
    frame_n = 1'b1;
    port_din = 1'b0;
  end

  // one port clock period, changes made on the fall
  task automatic pulse;
    #24 port_clock = 1'b1;
    #24 port_clock = 1'b0;
  endtask : pulse

  // clocks with the frame line high, data released
  task automatic idle(input int n);
    repeat (n) begin
      port_din = ~port_din;
      pulse();
    end
  endtask : idle

  // one word, msb first, nb bits then frame closed
  task automatic xfer(input logic [15:0] w, input int nb,
                      output logic [7:0] rd);
    int k;
    rd = 8'h00;
    for (k = 0; k < nb; k++) begin
      frame_n = 1'b0;
      port_din = w[15 - k];
      pulse();
      if (k >= 8) begin
        rd = {rd[6:0], port_dout & port_dout_oe};
      end
    end
    frame_n = 1'b1;
    idle(2);
  endtask : xfer
endmodule : ccr_host_model

`default_nettype wire

// [dv/ccr_top_properties.sv]
// Purpose: port checks of the codec control register bank
// Assumes: port clock runs while sys_rst is high
// Notes: a small write model on the port clock tracks the levels

`timescale 1ns/1ps
`default_nettype none

// ****************************************************************
// port checker
// ****************************************************************
module ccr_top_checker (
  // system side
  input wire logic clock,
  input wire logic sys_rst,
  // serial port
  input wire logic port_clock,
  input wire logic frame_n,
  input wire logic port_din,
  input wire logic port_dout,
  input wire logic port_dout_oe,
  // status and levels
  input wire logic adc_overflow,
  input wire ccr_pkg::ccr_ctrl_s ctrl
);
  logic [4:0] cnt_reg; // edges inside the frame
  logic [14:0] sh_reg; // last bits taken
  logic [7:0] m1_reg; // expected first register
  logic [7:0] m2_reg; // expected second register
  logic [3:0] idle_reg; // system cycles with frame line high
  wire logic [15:0] word_w = {sh_reg, port_din}; // word at edge 16
  wire logic wr_ok_w = (cnt_reg == 5'h0F) && !frame_n &&
                       (word_w[15:13] == 3'h0); // legal write

  // bit counter and write model
  always_ff @(posedge port_clock) begin
    sh_reg <= {sh_reg[13:0], port_din};
    if (sys_rst) begin
      cnt_reg <= 5'h00;
      m1_reg <= 8'h00;
      m2_reg <= 8'h00;
    end else if (frame_n) begin
      cnt_reg <= 5'h00;
    end else begin
      cnt_reg <= (cnt_reg == 5'h10) ? cnt_reg : cnt_reg + 5'h01;
      if (wr_ok_w && word_w[12:8] == ccr_pkg::ADDR_CTRL1) begin
        m1_reg <= word_w[7:0];
      end
      if (wr_ok_w && word_w[12:8] == ccr_pkg::ADDR_CTRL2) begin
        m2_reg <= word_w[7:0];
      end
    end
  end

  // quiet time seen on the system clock
  always_ff @(posedge clock) begin
    if (sys_rst || !frame_n) begin
      idle_reg <= 4'h0;
    end else if (idle_reg != 4'hF) begin
      idle_reg <= idle_reg + 4'h1;
    end
  end

  reset_clears_ctrl_a: assert property (@(posedge clock)
    disable iff (sys_rst) $fell(sys_rst) |-> ctrl == '0)
    else $error("ctrl not cleared by reset");
  frame_opens_a: assert property (@(posedge port_clock)
    disable iff (sys_rst) $fell(frame_n) |=> port_dout_oe)
    else $error("output enable missing in frame");
  frame_closes_a: assert property (@(posedge port_clock)
    disable iff (sys_rst)
    port_dout_oe && frame_n |=> !port_dout_oe && !port_dout)
    else $error("output enable kept after frame");
  dout_quiet_a: assert property (@(posedge port_clock)
    disable iff (sys_rst) !port_dout_oe |-> !port_dout)
    else $error("data out high while not driving");
  header_quiet_a: assert property (@(posedge port_clock)
    disable iff (sys_rst)
    port_dout_oe && cnt_reg <= 5'h08 |-> !port_dout)
    else $error("reply high byte not zero");
  ctrl_steady_a: assert property (@(posedge clock)
    disable iff (sys_rst) idle_reg == 4'hF |-> $stable(ctrl))
    else $error("ctrl moved without a frame");
  reg_one_fields_a: assert property (@(posedge clock)
    disable iff (sys_rst) idle_reg == 4'hE |->
    {ctrl.soft_reset, ctrl.power_down, ctrl.digital_loop,
     ctrl.analog_loop, ctrl.monitor_from_line,
     ctrl.monitor_gain} == m1_reg)
    else $error("first register levels wrong");
  reg_two_fields_a: assert property (@(posedge clock)
    disable iff (sys_rst) idle_reg == 4'hE |->
    {ctrl.line_gain, ctrl.dac_gain, ctrl.speaker_on} == m2_reg[7:1])
    else $error("second register levels wrong");
  ovf_keeps_ctrl_a: assert property (@(posedge clock)
    disable iff (sys_rst) adc_overflow && idle_reg > 4'h7 |=>
    $stable(ctrl))
    else $error("overflow moved a control level");
endmodule : ccr_top_checker

bind ccr_top ccr_top_checker u_chk (.clock(clock), .sys_rst(sys_rst),
  .port_clock(port_clock), .frame_n(frame_n), .port_din(port_din),
  .port_dout(port_dout), .port_dout_oe(port_dout_oe),
  .adc_overflow(adc_overflow), .ctrl(ctrl));

`default_nettype wire

// [dv/testbench.sv]
// Purpose: self-checking bench of the control register bank
// Assumes: host model drives the serial port
// Notes: port clock runs during reset and between checks

`timescale 1ns/1ps
`default_nettype none

// ****************************************************************
// testbench
// ****************************************************************
module testbench;
  logic clock; // system clock
  logic sys_rst; // synchronous reset
  logic adc_overflow; // converter overflow level
  wire logic port_clock, frame_n, port_din, port_dout, port_dout_oe;
  wire ccr_pkg::ccr_ctrl_s ctrl; // control levels
  int fail_count; // mismatches
  int num_checks; // comparisons
  logic [7:0] s1; // shadow of first register
  logic [7:0] s2; // shadow of second register
  logic [7:0] rd; // reply byte
  int i;

  ccr_top u_dut (.clock(clock), .sys_rst(sys_rst),
    .port_clock(port_clock), .frame_n(frame_n), .port_din(port_din),
    .port_dout(port_dout), .port_dout_oe(port_dout_oe),
    .adc_overflow(adc_overflow), .ctrl(ctrl));
  ccr_host_model u_host (.port_clock(port_clock), .frame_n(frame_n),
    .port_din(port_din), .port_dout(port_dout),
    .port_dout_oe(port_dout_oe));

  // 40 MHz clock
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  // compare and count
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // legal write, top bits kept zero
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    u_host.xfer({3'h0, a, d}, 16, rd);
  endtask : wr

  // read and compare the reply byte
  task automatic rd_chk(input logic [4:0] a, input logic [7:0] e);
    u_host.xfer({3'h1, a, 8'h00}, 16, rd);
    check({8'h00, rd}, {8'h00, e});
  endtask : rd_chk

  // let the crossing finish, then compare the levels
  task automatic settle;
    u_host.idle(12);
    check({1'b0, ctrl}, {1'b0, s1, s2[7:1]});
  endtask : settle

  // verdict
  task automatic tally_and_finish;
    if (fail_count == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : tally_and_finish

  // hang guard, 40000 system clocks
  initial begin
    #1000000;
    fail_count++;
    $display("ERROR %0t run did not finish in time", $time);
    tally_and_finish();
  end

  // main sequence
  initial begin
    fail_count = 0;
    num_checks = 0;
    sys_rst = 1'b1;
    adc_overflow = 1'b0;
    s1 = 8'h00;
    s2 = 8'h00;
    u_host.idle(6);
    @(posedge clock) sys_rst <= 1'b0;
    settle();
    rd_chk(ccr_pkg::ADDR_CTRL1, 8'h00);
    rd_chk(ccr_pkg::ADDR_CTRL2, 8'h00);
    // monitor gain codes 0 to 5, upper bits toggling
    for (i = 0; i < 6; i++) begin
      s1 = {i[0], ~i[0], i[1], i[2], i[0], i[2:0]};
      wr(ccr_pkg::ADDR_CTRL1, s1);
      settle();
      rd_chk(ccr_pkg::ADDR_CTRL1, s1);
    end
    // line and dac gain codes 0 to 4, overflow bit written high
    for (i = 0; i < 5; i++) begin
      s2 = {i[2:0], i[2:0], i[0], 1'b0};
      wr(ccr_pkg::ADDR_CTRL2, s2 | 8'h01);
      settle();
      rd_chk(ccr_pkg::ADDR_CTRL2, s2);
    end
    // refused words: top bits set, unmapped, cut short
    u_host.xfer(16'hC1FF, 16, rd);
    u_host.xfer(16'h03FF, 16, rd);
    u_host.xfer(16'h01FF, 10, rd);
    settle();
    rd_chk(5'h03, 8'h00);
    rd_chk(ccr_pkg::ADDR_CTRL1, s1);
    // overflow sets the status bit, a read clears it
    @(posedge clock) adc_overflow <= 1'b1;
    repeat (8) @(posedge clock);
    adc_overflow <= 1'b0;
    u_host.idle(12);
    rd_chk(ccr_pkg::ADDR_CTRL2, s2 | 8'h01);
    u_host.idle(12);
    rd_chk(ccr_pkg::ADDR_CTRL2, s2);
    // second reset in mid run
    @(posedge clock) sys_rst <= 1'b1;
    u_host.idle(6);
    @(posedge clock) sys_rst <= 1'b0;
    s1 = 8'h00;
    s2 = 8'h00;
    settle();
    rd_chk(ccr_pkg::ADDR_CTRL1, 8'h00);
    rd_chk(ccr_pkg::ADDR_CTRL2, 8'h00);
    tally_and_finish();
  end
endmodule : testbench

`default_nettype wire

// [hdl/ccr_sync.sv]
// Purpose: two flip-flop level synchroniser
// Assumes: input comes from another clock domain or a pin
// Notes: first stage feeds only the second stage

`timescale 1ns/1ps
`default_nettype none

// ****************************************************************
// level synchroniser
// ****************************************************************
module ccr_sync #(
  parameter int unsigned W = 1
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // data
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta_reg; // first stage, read only by q

  // two stages, cleared by a synchronous reset
  always_ff @(posedge clock) begin
    if (rst) begin
      meta_reg <= '0;
      q <= '0;
    end else begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end

endmodule : ccr_sync

`default_nettype wire

// [hdl/ccr_toggle_rx.sv]
// Purpose: turns a toggle from another domain into a one-cycle pulse
// Assumes: the toggle changes no faster than three local cycles
// Notes: edge found after the synchroniser, never on its first stage

`timescale 1ns/1ps
`default_nettype none

// ****************************************************************
// toggle event receiver
// ****************************************************************
module ccr_toggle_rx (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // event
  input wire logic tgl,
  output logic pulse
);

  logic tgl_sync; // synchronised toggle
  logic last_reg; // previous synchronised value

  // bring the toggle into this domain
  ccr_sync #(.W(1)) u_sync (
    .clock(clock),
    .rst(rst),
    .d(tgl),
    .q(tgl_sync)
  );

  // remember the last level
  always_ff @(posedge clock) begin
    if (rst) begin
      last_reg <= 1'b0;
    end else begin
      last_reg <= tgl_sync;
    end
  end

  // any change is one event
  assign pulse = tgl_sync ^ last_reg;

endmodule : ccr_toggle_rx

`default_nettype wire

// [hdl/ccr_top.sv]
// Purpose: codec control register bank behind the serial data port
// Assumes: host frames secondary words on the serial port, msb first
// Notes: registers live on clock, the shifter on the port clock

`timescale 1ns/1ps
`default_nettype none

// ****************************************************************
// codec control register bank
// ****************************************************************
// Function
// - bits 12..8 carry the register address
// - bits 7..0 carry the write data
// - bit 13 zero writes, one reads
// - first register bit 7 is software reset
// - first register bit 6 is power-down
// - first register bit 5 is digital loopback
// - first register bit 4 is analog loopback
// - first register bit 3 picks monitor source
// - first register bits 2..0 monitor gain
// - second register bits 7..5 line gain
// - second register bits 4..2 dac gain
// - second register bit 1 speaker on or mute
// - second register bit 0 sticky adc overflow
module ccr_top (
  // system clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // serial port, on the port clock
  input wire logic port_clock,
  input wire logic frame_n,
  input wire logic port_din,
  output logic port_dout,
  output logic port_dout_oe,
  // status from the converter
  input wire logic adc_overflow,
  // control levels
  output ccr_pkg::ccr_ctrl_s ctrl
);

  // ****************************************************************
  // declarations
  // ****************************************************************

  // system domain
  logic [7:0] ctrl1_reg; // first control register
  logic [7:0] ctrl1_next;
  logic [7:0] ctrl2_reg; // second control register
  logic [7:0] ctrl2_next;
  logic [15:0] cmd_reg; // last word taken from the port
  logic [15:0] cmd_next;
  logic cmd_vld_reg; // cmd_reg holds a fresh word
  logic cmd_vld_next;
  logic [15:0] snap_reg; // registers offered to the port side
  logic [15:0] snap_next;
  logic snap_req_reg; // toggles with each new offer
  logic snap_req_next;
  logic snap_ack_sync; // port side acknowledge, synchronised
  logic ovf_sync; // converter overflow, synchronised
  logic word_pulse; // one port word has arrived
  ccr_pkg::ccr_word_s cmd_word; // field view of cmd_reg
  logic cmd_ok; // top bits zero and address is one of the two registers
  logic wr_ctrl1; // write to the first register
  logic wr_ctrl2; // write to the second register
  logic rd_ctrl2; // read of the second register
  logic snap_free; // port side has taken the last offer

  // port domain
  logic port_rst; // system reset seen on the port clock
  ccr_pkg::ccr_link_state_e ls_reg; // shifter state
  ccr_pkg::ccr_link_state_e ls_next;
  logic [3:0] cnt_reg; // bit slot counter
  logic [3:0] cnt_next;
  logic [15:0] rx_reg; // incoming shift register
  logic [15:0] rx_next;
  logic [7:0] tx_reg; // outgoing reply byte
  logic [7:0] tx_next;
  logic dout_next;
  logic oe_next;
  logic [15:0] xfer_reg; // finished word, held for the system side
  logic [15:0] xfer_next;
  logic xfer_tgl_reg; // toggles once per finished word
  logic xfer_tgl_next;
  logic [15:0] psnap_reg; // port copy of both registers
  logic [15:0] psnap_next;
  logic psnap_ack_reg; // acknowledge toggle
  logic psnap_ack_next;
  logic snap_req_sync; // offer toggle, synchronised
  ccr_pkg::ccr_word_s head_word; // header bits as a word view
  logic head_ok; // header names a register
  logic [7:0] reply_byte; // byte returned on a read
  logic frame_on; // frame sync asserted
  logic head_done; // this edge takes the last header bit
  logic word_done; // this edge takes the last word bit

  // ****************************************************************
  // crossings
  // ****************************************************************

  // overflow pin into the system domain
  ccr_sync #(.W(1)) u_ovf_sync (
    .clock(clock),
    .rst(sys_rst),
    .d(adc_overflow),
    .q(ovf_sync)
  );

  // snapshot acknowledge back into the system domain
  ccr_sync #(.W(1)) u_ack_sync (
    .clock(clock),
    .rst(sys_rst),
    .d(psnap_ack_reg),
    .q(snap_ack_sync)
  );

  // finished word event into the system domain
  ccr_toggle_rx u_word_rx (
    .clock(clock),
    .rst(sys_rst),
    .tgl(xfer_tgl_reg),
    .pulse(word_pulse)
  );

  // system reset onto the port clock
  ccr_sync #(.W(1)) u_rst_sync (
    .clock(port_clock),
    .rst(1'b0),
    .d(sys_rst),
    .q(port_rst)
  );

  // snapshot offer onto the port clock
  ccr_sync #(.W(1)) u_req_sync (
    .clock(port_clock),
    .rst(port_rst),
    .d(snap_req_reg),
    .q(snap_req_sync)
  );

  // ****************************************************************
  // system side decode
  // ****************************************************************

  // take a word when the port side reports one
  assign cmd_next = word_pulse ? xfer_reg : cmd_reg;
  assign cmd_vld_next = word_pulse;

  // split the word into its fields
  assign cmd_word = ccr_pkg::ccr_word_s'(cmd_reg);
  assign cmd_ok = ccr_pkg::ccr_word_ok(cmd_word);

  // direction and address decode
  assign wr_ctrl1 = cmd_vld_reg && cmd_ok &&
                    (cmd_word.rd == ccr_pkg::RW_WRITE) &&
                    (cmd_word.addr == ccr_pkg::ADDR_CTRL1);
  assign wr_ctrl2 = cmd_vld_reg && cmd_ok &&
                    (cmd_word.rd == ccr_pkg::RW_WRITE) &&
                    (cmd_word.addr == ccr_pkg::ADDR_CTRL2);
  assign rd_ctrl2 = cmd_vld_reg && cmd_ok &&
                    (cmd_word.rd != ccr_pkg::RW_WRITE) &&
                    (cmd_word.addr == ccr_pkg::ADDR_CTRL2);

  // first register takes the whole data byte
  assign ctrl1_next = wr_ctrl1 ? cmd_word.data : ctrl1_reg;

  // second register: data above, overflow flag kept by hardware
  assign ctrl2_next[7:1] = wr_ctrl2 ? cmd_word.data[7:1]
                                    : ctrl2_reg[7:1];
  // flag set by overflow wins over the clear on read
  assign ctrl2_next[ccr_pkg::C2_ADC_OVF] =
    ovf_sync || (ctrl2_reg[ccr_pkg::C2_ADC_OVF] && !rd_ctrl2);

  // offer new copies once the last one was taken
  assign snap_free = (snap_ack_sync == snap_req_reg);
  assign snap_next = snap_free ? {ctrl1_reg, ctrl2_reg} : snap_reg;
  assign snap_req_next = snap_free ? !snap_req_reg : snap_req_reg;

  // ****************************************************************
  // system side registers
  // ****************************************************************

  // control registers, cleared by reset
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      ctrl1_reg <= ccr_pkg::CTRL1_RESET;
      ctrl2_reg <= ccr_pkg::CTRL2_RESET;
    end else begin
      ctrl1_reg <= ctrl1_next;
      ctrl2_reg <= ctrl2_next;
    end
  end

  // command capture
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      cmd_reg <= 16'h0000;
      cmd_vld_reg <= 1'b0;
    end else begin
      cmd_reg <= cmd_next;
      cmd_vld_reg <= cmd_vld_next;
    end
  end

  // snapshot offer, data held while the toggle is pending
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      snap_reg <= 16'h0000;
      snap_req_reg <= 1'b0;
    end else begin
      snap_reg <= snap_next;
      snap_req_reg <= snap_req_next;
    end
  end

  // ****************************************************************
  // control outputs, plain wiring of register bits
  // ****************************************************************

  assign ctrl.soft_reset = ctrl1_reg[ccr_pkg::C1_SOFT_RST];
  assign ctrl.power_down = ctrl1_reg[ccr_pkg::C1_PWR_DN];
  assign ctrl.digital_loop = ctrl1_reg[ccr_pkg::C1_DIG_LOOP];
  assign ctrl.analog_loop = ctrl1_reg[ccr_pkg::C1_ANA_LOOP];
  assign ctrl.monitor_from_line = ctrl1_reg[ccr_pkg::C1_MON_SRC];
  assign ctrl.monitor_gain =
    ctrl1_reg[ccr_pkg::C1_MON_GAIN_HI:ccr_pkg::C1_MON_GAIN_LO];
  assign ctrl.line_gain =
    ctrl2_reg[ccr_pkg::C2_LINE_GAIN_HI:ccr_pkg::C2_LINE_GAIN_LO];
  assign ctrl.dac_gain =
    ctrl2_reg[ccr_pkg::C2_DAC_GAIN_HI:ccr_pkg::C2_DAC_GAIN_LO];
  assign ctrl.speaker_on = ctrl2_reg[ccr_pkg::C2_SPK_ON];

  // ****************************************************************
  // port side decode
  // ****************************************************************

  // frame sync is active low and synchronous to the port clock
  assign frame_on = !frame_n;
  assign rx_next = {rx_reg[14:0], port_din};
  assign head_done = (ls_reg == ccr_pkg::LS_SHIFT) &&
                     (cnt_reg == ccr_pkg::CNT_HEAD_LAST);
  assign word_done = (ls_reg == ccr_pkg::LS_SHIFT) &&
                     (cnt_reg == ccr_pkg::CNT_WORD_LAST);

  // header bits just received, data byte still unknown
  assign head_word = ccr_pkg::ccr_word_s'({rx_next[7:0],
                                          ccr_pkg::READ_IDLE});
  assign head_ok = ccr_pkg::ccr_word_ok(head_word);

  // pick the addressed copy, zero for writes and bad addresses
  assign reply_byte =
    (!head_ok || (head_word.rd == ccr_pkg::RW_WRITE)) ?
      ccr_pkg::READ_IDLE :
    (head_word.addr == ccr_pkg::ADDR_CTRL1) ? psnap_reg[15:8] :
      psnap_reg[7:0];

  // take a new copy when the offer toggle differs from the ack
  assign psnap_next = (snap_req_sync != psnap_ack_reg) ? snap_reg
                                                       : psnap_reg;
  assign psnap_ack_next = snap_req_sync;

  // finished word and its event toggle
  assign xfer_next = word_done && frame_on ? rx_next : xfer_reg;
  assign xfer_tgl_next = (word_done && frame_on) ? !xfer_tgl_reg
                                                 : xfer_tgl_reg;

  // ****************************************************************
  // port side state machine
  // ****************************************************************

  // next state, counter, reply shifter and pin drive
  always_comb begin
    ls_next = ls_reg;
    cnt_next = cnt_reg;
    tx_next = tx_reg;
    dout_next = 1'b0;
    oe_next = 1'b0;
    case (ls_reg)
      ccr_pkg::LS_IDLE: begin
        // first bit comes with the frame sync
        if (frame_on) begin
          ls_next = ccr_pkg::LS_SHIFT;
          cnt_next = ccr_pkg::CNT_ONE;
          oe_next = 1'b1;
        end
      end
      ccr_pkg::LS_SHIFT: begin
        if (!frame_on) begin
          // short frame, dropped
          ls_next = ccr_pkg::LS_IDLE;
          cnt_next = ccr_pkg::CNT_ZERO;
        end else if (word_done) begin
          // last bit, wait for the frame to close
          ls_next = ccr_pkg::LS_DONE;
          cnt_next = ccr_pkg::CNT_ZERO;
          dout_next = tx_reg[7];
          oe_next = 1'b1;
        end else begin
          cnt_next = cnt_reg + ccr_pkg::CNT_ONE;
          oe_next = 1'b1;
          if (head_done) begin
            // header complete, load the reply byte
            tx_next = reply_byte;
          end else if (cnt_reg > ccr_pkg::CNT_HEAD_LAST) begin
            // reply byte out, msb first
            dout_next = tx_reg[7];
            tx_next = {tx_reg[6:0], 1'b0};
          end
        end
      end
      ccr_pkg::LS_DONE: begin
        // keep driving until the frame sync goes away
        if (frame_on) begin
          oe_next = 1'b1;
        end else begin
          ls_next = ccr_pkg::LS_IDLE;
        end
      end
      default: begin
        ls_next = ccr_pkg::LS_IDLE;
        cnt_next = ccr_pkg::CNT_ZERO;
      end
    endcase
  end

  // ****************************************************************
  // port side registers
  // ****************************************************************

  // shifter state and pin drive
  always_ff @(posedge port_clock) begin
    if (port_rst) begin
      ls_reg <= ccr_pkg::LS_IDLE;
      cnt_reg <= ccr_pkg::CNT_ZERO;
      rx_reg <= 16'h0000;
      tx_reg <= 8'h00;
      port_dout <= 1'b0;
      port_dout_oe <= 1'b0;
    end else begin
      ls_reg <= ls_next;
      cnt_reg <= cnt_next;
      rx_reg <= rx_next;
      tx_reg <= tx_next;
      port_dout <= dout_next;
      port_dout_oe <= oe_next;
    end
  end

  // handover to the system side
  always_ff @(posedge port_clock) begin
    if (port_rst) begin
      xfer_reg <= 16'h0000;
      xfer_tgl_reg <= 1'b0;
      psnap_reg <= 16'h0000;
      psnap_ack_reg <= 1'b0;
    end else begin
      xfer_reg <= xfer_next;
      xfer_tgl_reg <= xfer_tgl_next;
      psnap_reg <= psnap_next;
      psnap_ack_reg <= psnap_ack_next;
    end
  end

endmodule : ccr_top

`default_nettype wire

// [include/ccr_pkg.sv]
// Purpose: shared constants and types of the codec control register bank
// Assumes: 16-bit secondary serial words, two 8-bit control registers
// Notes: field positions and codes are named here; the logic also writes some bit slices, such as ctrl2_reg[7:1], by number

// ****************************************************************
// package of the codec control register bank
// ****************************************************************
package ccr_pkg;

  // word geometry
  localparam int unsigned WORD_W = 16; // secondary word width
  localparam int unsigned DATA_W = 8; // register width
  localparam int unsigned ADDR_W = 5; // register address width
  localparam int unsigned SNAP_W = 2 * DATA_W; // both registers side by side

  // register addresses
  localparam logic [4:0] ADDR_CTRL1 = 5'h01; // reset/power/loop/monitor
  localparam logic [4:0] ADDR_CTRL2 = 5'h02; // gains and overflow
  localparam logic [1:0] TOP_BITS_OK = 2'h0; // top two bits of a word
  localparam logic RW_WRITE = 1'b0; // direction bit value for a write

  // reset values
  localparam logic [7:0] CTRL1_RESET = 8'h00;
  localparam logic [7:0] CTRL2_RESET = 8'h00;
  localparam logic [7:0] READ_IDLE = 8'h00; // reply to a bad address

  // first control register fields
  localparam int unsigned C1_SOFT_RST = 7;
  localparam int unsigned C1_PWR_DN = 6;
  localparam int unsigned C1_DIG_LOOP = 5;
  localparam int unsigned C1_ANA_LOOP = 4;
  localparam int unsigned C1_MON_SRC = 3;
  localparam int unsigned C1_MON_GAIN_HI = 2;
  localparam int unsigned C1_MON_GAIN_LO = 0;

  // second control register fields
  localparam int unsigned C2_LINE_GAIN_HI = 7;
  localparam int unsigned C2_LINE_GAIN_LO = 5;
  localparam int unsigned C2_DAC_GAIN_HI = 4;
  localparam int unsigned C2_DAC_GAIN_LO = 2;
  localparam int unsigned C2_SPK_ON = 1;
  localparam int unsigned C2_ADC_OVF = 0;

  // bit counter of the serial shifter
  localparam logic [3:0] CNT_ZERO = 4'h0;
  localparam logic [3:0] CNT_ONE = 4'h1;
  localparam logic [3:0] CNT_HEAD_LAST = 4'h7; // last bit of the header
  localparam logic [3:0] CNT_WORD_LAST = 4'hF; // last bit of the word

  // link state machine, gray along idle -> shift -> done
  typedef enum logic [1:0] {
    LS_IDLE = 2'b00,
    LS_SHIFT = 2'b01,
    LS_DONE = 2'b11
  } ccr_link_state_e;

  // secondary word layout, msb first on the wire
  typedef struct packed {
    logic [1:0] top; // must be zero
    logic rd; // one reads, zero writes
    logic [4:0] addr; // register address
    logic [7:0] data; // write data
  } ccr_word_s;

  // control levels handed to the analog and datapath logic
  typedef struct packed {
    logic soft_reset; // software reset asserted
    logic power_down; // software power-down enabled
    logic digital_loop; // digital loopback
    logic analog_loop; // analog loopback
    logic monitor_from_line; // one: line gain stage, zero: dac
    logic [2:0] monitor_gain; // monitor amplifier gain code
    logic [2:0] line_gain; // line_receive_input gain code
    logic [2:0] dac_gain; // dac output gain code
    logic speaker_on; // speaker driver 0 dB, else muted
  } ccr_ctrl_s;

  // true when the top bits are zero and the word names one of the two registers
  function automatic logic ccr_word_ok(input ccr_word_s w);
    ccr_word_ok = (w.top == TOP_BITS_OK) &&
                  ((w.addr == ADDR_CTRL1) || (w.addr == ADDR_CTRL2));
  endfunction : ccr_word_ok

endpackage : ccr_pkg
